/* nck_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nck_defs.svh"

module nck_reg_bank #(
  parameter int NVM_WORDS = 16
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Decoded word transaction from the management interface
  input wire logic [7:0] cmd_code_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic rd_en_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_refused_o,
  // Settings image and its store/restore/boot events
  input wire logic [NVM_WORDS*16-1:0] nvm_image_i,
  input wire logic [15:0] nvm_key_i,
  input wire logic boot_done_i,
  input wire logic nvm_op_done_i,
  // Device state
  input wire logic conversion_on_i,
  input wire logic fault_response_i,
  input wire logic [15:0] fine_write_guard_i,
  output nck_pkg::nck_force_s force_o,
  output logic store_allowed_o,
  output logic guard_write_allowed_o,
  output logic crc_busy_o
);
  import nck_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire logic hit_crc = (cmd_code_i == `NCK_CMD_CRC);
  wire logic hit_inj = (cmd_code_i == `NCK_CMD_INJ);
  wire logic hit_key = (cmd_code_i == `NCK_CMD_KEY);
  wire logic wr_inj = wr_en_i && hit_inj;
  wire logic wr_key = wr_en_i && hit_key;

  // ----------------------------------------
  // Checksum engine
  // ----------------------------------------
  localparam int IDX_W = (NVM_WORDS > 1) ? $clog2(NVM_WORDS) : 1;
  nck_crc_e crc_state; // Engine state
  logic [IDX_W-1:0] crc_idx; // Word being folded in
  logic [15:0] crc_acc; // Running remainder
  logic [15:0] settings_crc_value; // Published checksum
  logic crc_pending; // Restart requested while busy

  // One word folded per clock, MSB first over 16 bits
  function automatic logic [15:0] crc_word(input logic [15:0] acc, input logic [15:0] d);
    logic [15:0] c;
    c = acc;
    for (int i = 15; i >= 0; i--) begin
      if (c[15] ^ d[i]) begin
        c = {c[14:0], 1'b0} ^ `NCK_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_word

  wire logic crc_trigger = boot_done_i || nvm_op_done_i;
  wire logic [15:0] crc_word_in = nvm_image_i[crc_idx*16 +: 16];
  wire logic [15:0] crc_next = crc_word(crc_acc, crc_word_in);
  wire logic crc_last = (crc_idx == IDX_W'(NVM_WORDS - 1));

  // Engine sequencing; a trigger during a run restarts after it so
  // that the published value always matches the newest image
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      crc_state <= NCK_CRC_IDLE;
      crc_idx <= '0;
      crc_acc <= `NCK_CRC_SEED;
      crc_pending <= 1'b0;
    end else begin
      case (crc_state)
        NCK_CRC_IDLE: begin
          crc_pending <= 1'b0;
          if (crc_trigger || crc_pending) begin
            crc_state <= NCK_CRC_RUN;
            crc_idx <= '0;
            crc_acc <= `NCK_CRC_SEED;
          end
        end
        NCK_CRC_RUN: begin
          if (crc_trigger) begin
            crc_pending <= 1'b1;
          end
          crc_acc <= crc_next;
          crc_idx <= crc_idx + IDX_W'(1);
          if (crc_last) begin
            crc_state <= NCK_CRC_DONE;
          end
        end
        NCK_CRC_DONE: begin
          // Publish then return to idle
          if (crc_trigger) begin
            crc_pending <= 1'b1;
          end
          crc_state <= NCK_CRC_IDLE;
        end
        default: begin
          crc_state <= NCK_CRC_IDLE;
        end
      endcase
    end
  end

  // Published checksum only changes at the end of a run
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      settings_crc_value <= 16'h0000;
    end else if (crc_state == NCK_CRC_DONE) begin
      settings_crc_value <= crc_acc;
    end
  end

  assign crc_busy_o = (crc_state != NCK_CRC_IDLE);

  // ----------------------------------------
  // Fault injection
  // ----------------------------------------
  logic [15:0] fault_injection_control;
  wire logic flt_persist = fault_injection_control[`NCK_FLT_PERSIST];
  wire logic wrn_persist = fault_injection_control[`NCK_WRN_PERSIST];
  // One-shot injections drop after one response; persistent ones stay
  wire logic [15:0] keep_mask = {1'b1, {7{flt_persist}}, 1'b1, {7{wrn_persist}}};

  // A write replaces the whole word; it beats a same-cycle response
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_injection_control <= 16'h0000;
    end else if (wr_inj) begin
      fault_injection_control <= wr_data_i & `NCK_INJ_MASK;
    end else if (fault_response_i) begin
      fault_injection_control <= fault_injection_control & keep_mask;
    end
  end

  // Conversion-off gating of injections
  wire logic [15:0] inj_live = fault_injection_control &
    (conversion_on_i ? `NCK_INJ_MASK : `NCK_INJ_OFF_OK);

  // Drive detector overrides; a clear bit leaves the detector alone
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      force_o <= '0;
    end else begin
      force_o <= '{overtemp_fault: inj_live[14], overcurrent_fault: inj_live[12],
        input_lockout: inj_live[11], input_overvoltage: inj_live[10],
        output_undervoltage: inj_live[9], output_overvoltage: inj_live[8],
        overcurrent_warning: inj_live[4], input_low_warning: inj_live[3],
        output_low_warning: inj_live[1], output_high_warning: inj_live[0]};
    end
  end

  // ----------------------------------------
  // Access key
  // ----------------------------------------
  logic [15:0] write_unlock_key; // Active key
  logic key_locked; // Protected actions blocked
  logic [1:0] fail_cnt; // Mismatches since last match, saturates at 3

  wire logic key_guarded = fine_write_guard_i[1];
  wire logic key_dead = (fail_cnt == `NCK_MAX_FAILS);
  wire logic key_ok_wr = wr_key && !key_guarded && !key_dead;
  wire logic key_match = (wr_data_i == write_unlock_key);

  // Key load at boot, then match/mismatch tracking
  // Boot reloads the key but keeps the failure count, so a lockout
  // survives a reboot and only a power-on reset lifts it
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      write_unlock_key <= `NCK_KEY_OPEN;
      key_locked <= 1'b0;
      fail_cnt <= 2'h0;
    end else if (boot_done_i) begin
      write_unlock_key <= nvm_key_i;
      key_locked <= (nvm_key_i != `NCK_KEY_OPEN);
    end else if (key_ok_wr) begin
      if (!key_locked) begin
        write_unlock_key <= wr_data_i;
      end else if (key_match) begin
        key_locked <= 1'b0;
        fail_cnt <= 2'h0;
      end else begin
        fail_cnt <= fail_cnt + 2'h1;
      end
    end
  end

  assign store_allowed_o = !key_locked;
  assign guard_write_allowed_o = !key_locked;

  // Key read codes never expose the key
  wire logic [15:0] key_code = !key_locked ? `NCK_RD_UNLOCKED :
    (fail_cnt == 2'h0) ? `NCK_RD_LOCKED0 :
    (fail_cnt == 2'h1) ? `NCK_RD_LOCKED1 :
    (fail_cnt == 2'h2) ? `NCK_RD_LOCKED2 : `NCK_RD_LOCKED3;

  // ----------------------------------------
  // Read and write answers
  // ----------------------------------------
  wire logic [15:0] rd_mux = hit_crc ? settings_crc_value :
    hit_inj ? fault_injection_control : hit_key ? key_code : 16'h0000;
  // A refused write is flagged so the host can tell a lockout from a mismatch
  wire logic wr_bad = wr_en_i && (hit_crc || (hit_key && (key_guarded || key_dead))
    || !(hit_crc || hit_inj || hit_key));

  // Registered answers one cycle after the request
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
      wr_refused_o <= 1'b0;
    end else begin
      rd_data_o <= rd_en_i ? rd_mux : 16'h0000;
      rd_valid_o <= rd_en_i;
      wr_refused_o <= wr_bad;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  crc_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_en_i && hit_crc && crc_state != NCK_CRC_DONE) |=>
    (settings_crc_value == $past(settings_crc_value)) && wr_refused_o)
    else $error("checksum changed by a write");
  crc_run_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (crc_trigger && crc_state == NCK_CRC_IDLE) |=> crc_state == NCK_CRC_RUN)
    else $error("checksum run not started");
  inj_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_inj |=> fault_injection_control == ($past(wr_data_i) & `NCK_INJ_MASK))
    else $error("injection write lost");
  flt_oneshot_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (fault_response_i && !wr_inj && !flt_persist) |=> fault_injection_control[14:8] == 7'h00)
    else $error("one-shot fault kept");
  wrn_persist_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (fault_response_i && !wr_inj && wrn_persist) |=> $stable(fault_injection_control[7:0]))
    else $error("persistent warning dropped");
  off_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !conversion_on_i |=> !(force_o.overtemp_fault || force_o.output_undervoltage))
    else $error("injection acted with conversion off");
  key_lockout_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (key_dead && !boot_done_i) |=> key_dead && $stable(key_locked))
    else $error("lockout left");
  key_code_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (rd_en_i && hit_key && key_locked && fail_cnt == 2'h1) |=> rd_data_o == 16'h001F)
    else $error("wrong key state code");
  key_guard_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_key && key_guarded && !boot_done_i) |=> $stable(write_unlock_key) && $stable(fail_cnt))
    else $error("guarded key write took effect");
  key_match_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (key_ok_wr && key_locked && key_match && !boot_done_i) |=> !key_locked && fail_cnt == 2'h0)
    else $error("matching key did not unlock");
  // Antecedents leave out boot cycles, where the key load takes priority
  key_replace_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (key_ok_wr && !key_locked && !boot_done_i) |=> write_unlock_key == $past(wr_data_i))
    else $error("open key write not taken");
  key_boot_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    boot_done_i |=> write_unlock_key == $past(nvm_key_i)
    && key_locked == ($past(nvm_key_i) != `NCK_KEY_OPEN))
    else $error("boot key load wrong");
  key_refuse_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_key && key_dead && !boot_done_i) |=> wr_refused_o && key_dead
    && $stable(write_unlock_key))
    else $error("key write after lockout not refused");
  crc_publish_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (crc_state == NCK_CRC_DONE) |=> settings_crc_value == $past(crc_acc))
    else $error("checksum not published");
  lockout_keep_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !conversion_on_i |=> force_o.input_lockout == $past(fault_injection_control[11])
    && force_o.output_overvoltage == $past(fault_injection_control[8]))
    else $error("lockout injection gated with conversion off");

  crc_done_c: cover property (@(posedge sys_clk_i) crc_state == NCK_CRC_DONE);
  key_dead_c: cover property (@(posedge sys_clk_i) key_dead);
  key_open_c: cover property (@(posedge sys_clk_i) key_locked ##1 !key_locked);
  inj_drop_c: cover property (@(posedge sys_clk_i) fault_response_i && !flt_persist
    && fault_injection_control[14]);
  key_refused_c: cover property (@(posedge sys_clk_i) wr_key && key_dead);
endmodule : nck_reg_bank
`default_nettype wire

/* nck_defs.svh */
`ifndef NCK_DEFS_SVH
`define NCK_DEFS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define NCK_CMD_CRC 8'hF0
`define NCK_CMD_INJ 8'hF1
`define NCK_CMD_KEY 8'hFA
// ----------------------------------------
// Checksum and key constants
// ----------------------------------------
`define NCK_CRC_POLY 16'h8005
`define NCK_CRC_SEED 16'hFFFF
`define NCK_KEY_OPEN 16'h0000
`define NCK_MAX_FAILS 2'h3
// ----------------------------------------
// Key state read codes
// ----------------------------------------
`define NCK_RD_UNLOCKED 16'h0000
`define NCK_RD_LOCKED0 16'h000F
`define NCK_RD_LOCKED1 16'h001F
`define NCK_RD_LOCKED2 16'h002F
`define NCK_RD_LOCKED3 16'h00FF
// ----------------------------------------
// Injection field positions
// ----------------------------------------
`define NCK_FLT_PERSIST 15
`define NCK_WRN_PERSIST 7
// Writable injection bits (reserved bits 13, 6, 5 and 2 held at zero)
`define NCK_INJ_MASK 16'hDF9B
// Injections that still act while conversion is off: lockout and output overvoltage
`define NCK_INJ_OFF_OK 16'h0900
`endif

/* nck_pkg.sv */
package nck_pkg;
  // Fault and warning detector overrides, one bit per detector
  typedef struct packed {
    logic overtemp_fault;
    logic overcurrent_fault;
    logic input_lockout;
    logic input_overvoltage;
    logic output_undervoltage;
    logic output_overvoltage;
    logic overcurrent_warning;
    logic input_low_warning;
    logic output_low_warning;
    logic output_high_warning;
  } nck_force_s;

  // Checksum engine states
  typedef enum logic [1:0] {
    NCK_CRC_IDLE = 2'b00,
    NCK_CRC_RUN = 2'b01,
    NCK_CRC_DONE = 2'b10
  } nck_crc_e;
endpackage : nck_pkg

/* nck_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Word-level management host
// ----------------------------------------
module nck_host_model (
  input wire logic clk_i,
  input wire logic refused_i,
  output logic [7:0] cmd_o,
  output logic wr_o,
  output logic [15:0] data_o,
  output logic rd_o
);
  // Idle lines at time zero
  initial begin
    cmd_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    data_o = 16'h0000;
  end

  // One whole word per call; command and data are inverted and wr/rd dropped on release so that
  // a stale command or data word can never pass for a live one
  task automatic req(input logic [7:0] c, input logic w, input logic [15:0] d,
                     output logic r);
    @(posedge clk_i);
    #1;
    cmd_o = c;
    data_o = d;
    wr_o = w;
    rd_o = !w;
    // The request is taken at this edge; the refusal flag it raises
    // stands for exactly one cycle, so it is read before the next edge
    @(posedge clk_i);
    #1;
    r = refused_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    cmd_o = ~c;
    data_o = ~d;
  endtask : req
endmodule : nck_host_model
`default_nettype wire

/* nvm_check_fault_sim_key_lock_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nck_defs.svh"
module nvm_check_fault_sim_key_lock_bench;
  import nck_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  localparam int NW = 2; // Short image keeps checksum runs brief
  localparam logic [15:0] KEY = 16'hA5C3;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] cmd;
  logic wr, rd, rvalid, wref, boot = 1'b0, opdone = 1'b0;
  logic conv = 1'b0, fresp = 1'b0, st_ok, gw_ok, busy;
  logic [15:0] wdata, rdata, nkey = 16'h0000, guard = 16'h0000, v;
  logic [NW*16-1:0] img = '0;
  nck_force_s frc;
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 34680;
  logic [15:0] exp_q[$]; // Expected read words, oldest first

  always #2.5 sys_clk_i = ~sys_clk_i;

  nck_reg_bank #(.NVM_WORDS(NW)) u_nck_reg_bank (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cmd_code_i(cmd), .wr_en_i(wr),
    .wr_data_i(wdata), .rd_en_i(rd), .rd_data_o(rdata), .rd_valid_o(rvalid),
    .wr_refused_o(wref), .nvm_image_i(img), .nvm_key_i(nkey), .boot_done_i(boot),
    .nvm_op_done_i(opdone), .conversion_on_i(conv), .fault_response_i(fresp),
    .fine_write_guard_i(guard), .force_o(frc), .store_allowed_o(st_ok),
    .guard_write_allowed_o(gw_ok), .crc_busy_o(busy));

  nck_host_model u_nck_host_model (.clk_i(sys_clk_i), .refused_i(wref),
    .cmd_o(cmd), .wr_o(wr), .data_o(wdata), .rd_o(rd));

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic cmp_force(input nck_force_s got, input nck_force_s exp);
    cmp(16'(got), 16'(exp));
  endtask : cmp_force

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  task automatic wr_chk(input logic [7:0] c, input logic [15:0] d, input logic er);
    logic r;
    u_nck_host_model.req(c, 1'b1, d, r);
    cmp({15'h0, r}, {15'h0, er});
  endtask : wr_chk

  // Expectation is queued before the request so the monitor always finds it
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    logic r;
    exp_q.push_back(e);
    u_nck_host_model.req(c, 1'b0, 16'h0000, r);
  endtask : rd_chk

  // Reference checksum: seed all ones, MSB first, word 0 first
  function automatic logic [15:0] crc(input logic [NW*16-1:0] im);
    logic [15:0] c;
    logic fb;
    c = `NCK_CRC_SEED;
    for (int w = 0; w < NW; w++) begin
      for (int b = 15; b >= 0; b--) begin
        fb = c[15] ^ im[w*16+b];
        c = {c[14:0], 1'b0} ^ (fb ? `NCK_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction : crc

  // Detector overrides expected from an injection word
  function automatic nck_force_s exp_force(input logic [15:0] x, input logic on);
    logic [15:0] m;
    m = on ? x : (x & `NCK_INJ_OFF_OK);
    return {m[14], m[12], m[11], m[10], m[9], m[8], m[4], m[3], m[1], m[0]};
  endfunction : exp_force

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Read monitor and watchdog
  // ----------------------------------------
  // Sampled mid-cycle, where the registered answer has settled
  always @(negedge sys_clk_i) begin
    if (rvalid === 1'b1) begin
      // An answer with no expectation behind it is always a mismatch
      if (exp_q.size() > 0) begin
        cmp(rdata, exp_q.pop_front());
      end else begin
        cmp(16'h0001, 16'h0000);
      end
    end
  end

  initial begin
    #20000;
    bad_count++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(3);
    sys_rst_i = 1'b0;
    rd_chk(`NCK_CMD_KEY, `NCK_RD_UNLOCKED);
    rd_chk(`NCK_CMD_INJ, 16'h0000);
    cmp({15'h0, st_ok}, 16'h0001);
    img = 32'($random(seed));
    nkey = KEY;
    boot = 1'b1;
    cyc(1);
    boot = 1'b0;
    cyc(NW + 4);
    rd_chk(`NCK_CMD_CRC, crc(img));
    rd_chk(`NCK_CMD_KEY, `NCK_RD_LOCKED0);
    cmp({15'h0, st_ok | gw_ok}, 16'h0000);
    wr_chk(`NCK_CMD_CRC, 16'h1234, 1'b1);
    rd_chk(`NCK_CMD_CRC, crc(img));
    wr_chk(8'h77, 16'h1234, 1'b1);
    guard = 16'h0002;
    wr_chk(`NCK_CMD_KEY, ~KEY, 1'b1);
    rd_chk(`NCK_CMD_KEY, `NCK_RD_LOCKED0);
    guard = 16'h0000;
    wr_chk(`NCK_CMD_KEY, ~KEY, 1'b0);
    rd_chk(`NCK_CMD_KEY, `NCK_RD_LOCKED1);
    wr_chk(`NCK_CMD_KEY, KEY, 1'b0);
    rd_chk(`NCK_CMD_KEY, `NCK_RD_UNLOCKED);
    cmp({15'h0, st_ok & gw_ok}, 16'h0001);
    wr_chk(`NCK_CMD_KEY, 16'h1111, 1'b0);
    rd_chk(`NCK_CMD_KEY, `NCK_RD_UNLOCKED);
    img = ~img;
    opdone = 1'b1;
    cyc(1);
    opdone = 1'b0;
    cmp({15'h0, busy}, 16'h0001);
    cyc(NW + 4);
    rd_chk(`NCK_CMD_CRC, crc(img));
    boot = 1'b1;
    cyc(1);
    boot = 1'b0;
    cyc(NW + 4);
    for (int i = 1; i <= 3; i++) begin
      wr_chk(`NCK_CMD_KEY, KEY ^ 16'(i), 1'b0);
      rd_chk(`NCK_CMD_KEY, (i == 1) ? `NCK_RD_LOCKED1 : (i == 2) ? `NCK_RD_LOCKED2
             : `NCK_RD_LOCKED3);
    end
    wr_chk(`NCK_CMD_KEY, KEY, 1'b1);
    rd_chk(`NCK_CMD_KEY, `NCK_RD_LOCKED3);
    // Only a power-on reset lifts the lockout; let the last answer land first
    cyc(1);
    sys_rst_i = 1'b1;
    cyc(3);
    sys_rst_i = 1'b0;
    rd_chk(`NCK_CMD_KEY, `NCK_RD_UNLOCKED);
    cmp({15'h0, st_ok & gw_ok}, 16'h0001);
    conv = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed)) | 16'h8080;
      wr_chk(`NCK_CMD_INJ, v, 1'b0);
      rd_chk(`NCK_CMD_INJ, v & `NCK_INJ_MASK);
      cmp_force(frc, exp_force(v, 1'b1));
      fresp = 1'b1;
      cyc(1);
      fresp = 1'b0;
      cyc(2);
      cmp_force(frc, exp_force(v, 1'b1));
      v = v & 16'h7F7F;
      wr_chk(`NCK_CMD_INJ, v, 1'b0);
      cyc(1);
      cmp_force(frc, exp_force(v, 1'b1));
      fresp = 1'b1;
      cyc(1);
      fresp = 1'b0;
      cyc(2);
      cmp_force(frc, '0);
    end
    conv = 1'b0;
    wr_chk(`NCK_CMD_INJ, 16'hDF9B, 1'b0);
    cyc(1);
    cmp_force(frc, exp_force(16'hDF9B, 1'b0));
    cyc(4);
    cmp(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule : nvm_check_fault_sim_key_lock_bench
`default_nettype wire
